// file: hdl/mgp_top.sv
// Multiplexed GPIO ports with Avalon-MM register access
//
// Summary of operation
// - Plain four-bit ports: per-bit direction
// - Per-pin software pull-up enable where offered
// - Open-drain port drives low only, no pull-up
// - Key port bits select I/O or key input
// - Single-pin port: I/O or interrupt zero
// - Interrupt inputs detect rising, falling or both
// - Output-only pin always drives its latch
// - Two-pin port: I/O, interrupt, clock, buzzer
// - Last interrupt-port pin carries timer clock, output
// - Reset input is active low
`timescale 1ns/1ps
module mgp_top
  import mgp_pkg::*;
(
  input  wire logic        CLK_SYS,
  input  wire logic        RST_B,
  input  wire logic [7:0]  AVS_ADDRESS,
  input  wire logic        AVS_READ,
  input  wire logic        AVS_WRITE,
  input  wire logic [31:0] AVS_WRITEDATA,
  input  wire logic [3:0]  AVS_BYTEENABLE,
  output logic      [31:0] AVS_READDATA,
  output logic             AVS_WAITREQUEST,
  output logic      [1:0]  AVS_RESPONSE,
  input  wire logic [3:0]  P3_IN,
  output logic      [3:0]  P3_OUT,
  output logic      [3:0]  P3_OE,
  output logic      [3:0]  P3_PULLUP,
  input  wire logic [3:0]  P4_IN,
  output logic      [3:0]  P4_OUT,
  output logic      [3:0]  P4_OE,
  output logic      [3:0]  P4_PULLUP,
  input  wire logic [3:0]  P5_IN,
  output logic      [3:0]  P5_OUT,
  output logic      [3:0]  P5_OE,
  output logic      [3:0]  P5_PULLUP,
  input  wire logic [3:0]  P6_IN,
  output logic      [3:0]  P6_OUT,
  output logic      [3:0]  P6_OE,
  input  wire logic [7:0]  P7_IN,
  output logic      [7:0]  P7_OUT,
  output logic      [7:0]  P7_OE,
  output logic      [7:0]  P7_PULLUP,
  input  wire logic        P12_IN,
  output logic             P12_OUT,
  output logic             P12_OE,
  output logic             P12_PULLUP,
  output logic             OUTPUT_ONLY_PIN,
  input  wire logic [1:0]  P14_IN,
  output logic      [1:0]  P14_OUT,
  output logic      [1:0]  P14_OE,
  output logic      [1:0]  P14_PULLUP,
  input  wire logic        TIMER_B_OUT,
  input  wire logic        CLOCK_OUT_SRC,
  input  wire logic        BUZZER_SRC,
  output logic             TIMER_B_COUNT_IN,
  output logic      [7:0]  KEY_IRQ_INPUTS,
  output logic      [7:0]  EXT_IRQ
);

  logic [63:0] pin_raw;
  logic [63:0] sync1;
  logic [63:0] sync2;
  logic [63:0] sync3;
  logic [63:0] filt;
  logic [63:0] filt_d;
  logic [7:0]  latch    [NPORT];
  logic [7:0]  dir      [NPORT];
  logic [7:0]  pull     [NPORT];
  logic [7:0]  mode     [NPORT];
  logic [7:0]  alt_src  [NPORT];
  logic [7:0]  alt_en   [NPORT];
  logic [7:0]  func_in  [NPORT];
  logic [7:0]  pin_out  [NPORT];
  logic [7:0]  pin_oe   [NPORT];
  logic [7:0]  pin_pu   [NPORT];
  logic [7:0]  rd_byte  [NPORT];
  logic [15:0] edge_cfg;
  logic        wreq;
  logic        wr_fire;
  logic [31:0] next_rdata;

  // Address decode shared by read and write paths
  function automatic logic addr_hit(input logic [7:0] a);
    addr_hit = ((a[7] == 1'b0) && (a[1:0] == 2'b00)) || (a == OFS_EDGE);
  endfunction

  // Gather pins into one flat vector, slot p at bits p*8
  always_comb
  begin
    pin_raw = '0;
    pin_raw[P3*PW +: 4]  = P3_IN;
    pin_raw[P4*PW +: 4]  = P4_IN;
    pin_raw[P5*PW +: 4]  = P5_IN;
    pin_raw[P6*PW +: 4]  = P6_IN;
    pin_raw[P7*PW +: 8]  = P7_IN;
    pin_raw[P12*PW]      = P12_IN;
    pin_raw[P14*PW +: 2] = P14_IN;
  end

  // Three-stage sync; level accepted once stages two and three agree
  always_ff @(posedge CLK_SYS)
  begin
    if (!RST_B)
    begin
      sync1  <= '0;
      sync2  <= '0;
      sync3  <= '0;
      filt   <= '0;
      filt_d <= '0;
    end
    else
    begin
      sync1  <= pin_raw;
      sync2  <= sync1;
      sync3  <= sync2;
      filt   <= (~(sync2 ^ sync3) & sync3) | ((sync2 ^ sync3) & filt);
      filt_d <= filt;
    end
  end

  // Bus slave: one wait cycle, then answer for exactly one cycle
  assign wr_fire = AVS_WRITE & ~wreq;

  always_comb
  begin
    next_rdata = '0;
    if (AVS_ADDRESS == OFS_EDGE)
      next_rdata[15:0] = edge_cfg;
    else
      next_rdata[7:0] = rd_byte[AVS_ADDRESS[6:4]];
  end

  always_ff @(posedge CLK_SYS)
  begin
    if (!RST_B)
    begin
      wreq         <= 1'b1;
      AVS_READDATA <= '0;
      AVS_RESPONSE <= RESP_OK;
    end
    else if ((AVS_READ | AVS_WRITE) & wreq)
    begin
      wreq         <= 1'b0;
      AVS_READDATA <= addr_hit(AVS_ADDRESS) ? next_rdata : '0;
      AVS_RESPONSE <= addr_hit(AVS_ADDRESS) ? RESP_OK : RESP_SLVERR;
    end
    else
      wreq <= 1'b1;
  end

  assign AVS_WAITREQUEST = wreq;

  // Edge select for all interrupt inputs
  always_ff @(posedge CLK_SYS)
  begin
    if (!RST_B)
      edge_cfg <= RST_EDGE;
    else if (wr_fire && AVS_ADDRESS == OFS_EDGE)
    begin
      if (AVS_BYTEENABLE[0])
        edge_cfg[7:0] <= AVS_WRITEDATA[7:0];
      if (AVS_BYTEENABLE[1])
        edge_cfg[15:8] <= AVS_WRITEDATA[15:8];
    end
  end

  // Alternate output sources feeding the pins
  always_comb
  begin
    for (int i = 0; i < NPORT; i++)
      alt_src[i] = '0;
    alt_src[P3][TMR_BIT]  = TIMER_B_OUT;
    alt_src[P14][CLK_BIT] = CLOCK_OUT_SRC;
    alt_src[P14][BUZ_BIT] = BUZZER_SRC;
  end

  for (genvar p = 0; p < NPORT; p++)
  begin : g_port
    logic sel;
    assign sel = wr_fire && addr_hit(AVS_ADDRESS) && !AVS_ADDRESS[7] &&
                 AVS_ADDRESS[6:4] == 3'(p) && AVS_BYTEENABLE[0];

    // Latch, direction, pull-up and mode per port
    always_ff @(posedge CLK_SYS)
    begin
      if (!RST_B)
      begin
        latch[p] <= RST_LATCH;
        dir[p]   <= RST_DIR & DIR_MASK[p];
        pull[p]  <= RST_PULL;
        mode[p]  <= RST_MODE;
      end
      else if (sel)
      begin
        case (AVS_ADDRESS[3:2])
          FLD_DATA: latch[p] <= AVS_WRITEDATA[7:0] & BIT_MASK[p];
          FLD_DIR:  dir[p]   <= AVS_WRITEDATA[7:0] & DIR_MASK[p];
          FLD_PULL: pull[p]  <= AVS_WRITEDATA[7:0] & PULL_MASK[p];
          FLD_MODE: mode[p]  <= AVS_WRITEDATA[7:0] & MODE_MASK[p];
          default:  latch[p] <= latch[p];
        endcase
      end
    end

    // Output pins latch, input pins return the filtered level
    always_comb
    begin
      case (AVS_ADDRESS[3:2])
        FLD_DATA: rd_byte[p] = (latch[p] & ~dir[p]) |
                               (filt[p*PW +: PW] & dir[p]);
        FLD_DIR:  rd_byte[p] = dir[p];
        FLD_PULL: rd_byte[p] = pull[p];
        default:  rd_byte[p] = mode[p];
      endcase
    end

    // Alternate outputs only in output direction; others force input
    assign alt_en[p]  = mode[p] & ALT_OUT_MASK[p] & ~dir[p];
    assign func_in[p] = mode[p] & ~alt_en[p];

    // Registered pin drive
    always_ff @(posedge CLK_SYS)
    begin
      if (!RST_B)
      begin
        pin_out[p] <= '0;
        pin_oe[p]  <= (p == P13) ? BIT_MASK[p] : 8'h00;
        pin_pu[p]  <= '0;
      end
      else if (p == P6)
      begin
        // Never drives high; the line floats up externally
        pin_out[p] <= '0;
        pin_oe[p]  <= ~dir[p] & ~latch[p] & BIT_MASK[p];
        pin_pu[p]  <= '0;
      end
      else if (p == P13)
      begin
        pin_out[p] <= latch[p];
        pin_oe[p]  <= BIT_MASK[p];
        pin_pu[p]  <= '0;
      end
      else
      begin
        pin_out[p] <= (alt_en[p] & alt_src[p]) |
                      (~alt_en[p] & latch[p]);
        pin_oe[p]  <= ~dir[p] & ~func_in[p] & BIT_MASK[p];
        // Pull-up only matters while the pin is not driven
        pin_pu[p]  <= pull[p] & (dir[p] | func_in[p]);
      end
    end
  end

  // Edge detectors for the external interrupt inputs
  for (genvar n = 0; n < 8; n++)
  begin : g_irq
    logic cur;
    logic prv;
    logic en;
    assign cur = filt[IRQ_PORT[n]*PW + IRQ_BIT[n]];
    assign prv = filt_d[IRQ_PORT[n]*PW + IRQ_BIT[n]];
    assign en  = IRQ_USED[n] & func_in[IRQ_PORT[n]][IRQ_BIT[n]];

    always_ff @(posedge CLK_SYS)
    begin
      if (!RST_B)
        EXT_IRQ[n] <= 1'b0;
      else
        EXT_IRQ[n] <= en &
          ((edge_cfg[2*n+EDGE_RISE] & cur & ~prv) |
           (edge_cfg[2*n+EDGE_FALL] & ~cur & prv));
    end
  end

  // Key and timer inputs handed to their consumers
  always_ff @(posedge CLK_SYS)
  begin
    if (!RST_B)
    begin
      KEY_IRQ_INPUTS   <= '0;
      TIMER_B_COUNT_IN <= 1'b0;
    end
    else
    begin
      KEY_IRQ_INPUTS   <= filt[P7*PW +: PW] & mode[P7];
      TIMER_B_COUNT_IN <= filt[P3*PW + TMR_BIT] &
                          func_in[P3][TMR_BIT];
    end
  end

  // Pin ports are slices of the drive flops
  assign P3_OUT          = pin_out[P3][3:0];
  assign P3_OE           = pin_oe[P3][3:0];
  assign P3_PULLUP       = pin_pu[P3][3:0];
  assign P4_OUT          = pin_out[P4][3:0];
  assign P4_OE           = pin_oe[P4][3:0];
  assign P4_PULLUP       = pin_pu[P4][3:0];
  assign P5_OUT          = pin_out[P5][3:0];
  assign P5_OE           = pin_oe[P5][3:0];
  assign P5_PULLUP       = pin_pu[P5][3:0];
  assign P6_OUT          = pin_out[P6][3:0];
  assign P6_OE           = pin_oe[P6][3:0];
  assign P7_OUT          = pin_out[P7];
  assign P7_OE           = pin_oe[P7];
  assign P7_PULLUP       = pin_pu[P7];
  assign P12_OUT         = pin_out[P12][0];
  assign P12_OE          = pin_oe[P12][0];
  assign P12_PULLUP      = pin_pu[P12][0];
  assign OUTPUT_ONLY_PIN = pin_out[P13][0];
  assign P14_OUT         = pin_out[P14][1:0];
  assign P14_OE          = pin_oe[P14][1:0];
  assign P14_PULLUP      = pin_pu[P14][1:0];

  // Checks on pin drive, interrupts and bus handshake
  default clocking cb @(posedge CLK_SYS); endclocking
  default disable iff (!RST_B);

  chk_plain_dir: assert property (
    P4_OE == ~$past(dir[P4][3:0]) && P5_OE == ~$past(dir[P5][3:0]))
    else $error("plain port enable does not follow direction");
  chk_pullup_input: assert property (
    P7_PULLUP == $past(pull[P7] & (dir[P7] | func_in[P7])))
    else $error("key port pull-up wrong");
  chk_open_drain: assert property (
    P6_OUT == 4'h0 && P6_OE == $past(~dir[P6][3:0] & ~latch[P6][3:0]))
    else $error("open-drain pin drove high or wrong enable");
  chk_key_input: assert property (
    (P7_OE & $past(mode[P7])) == 8'h00)
    else $error("key input pin is being driven");
  chk_irq0_rise: assert property (
    ($rose(filt[P12*PW]) && func_in[P12][0] && edge_cfg[EDGE_RISE])
    |=> EXT_IRQ[0])
    else $error("rising edge on interrupt zero missed");
  chk_irq_quiet: assert property (
    (filt == filt_d) |=> (EXT_IRQ == 8'h00))
    else $error("interrupt without an edge");
  chk_out_only: assert property (
    OUTPUT_ONLY_PIN == $past(latch[P13][0]))
    else $error("output-only pin not following latch");
  chk_clock_route: assert property (
    $past(alt_en[P14][CLK_BIT]) |-> P14_OUT[0] == $past(CLOCK_OUT_SRC))
    else $error("clock output not routed");
  chk_timer_route: assert property (
    $past(func_in[P3][TMR_BIT]) |->
    TIMER_B_COUNT_IN == $past(filt[P3*PW + TMR_BIT]))
    else $error("timer count input not routed");
  chk_reset_idle: assert property (
    !$past(RST_B) |-> AVS_WAITREQUEST && P4_OE == 4'h0)
    else $error("outputs not idle after reset");
  chk_latch_drive: assert property (
    $past(~dir[P4][0]) |-> P4_OUT[0] == $past(latch[P4][0]))
    else $error("output pin not driving latch");
  chk_bus_answer: assert property (
    ((AVS_READ | AVS_WRITE) && AVS_WAITREQUEST) |=> !AVS_WAITREQUEST ##1
    AVS_WAITREQUEST)
    else $error("bus answer not one cycle");

  cov_irq0: cover property (EXT_IRQ[0]);
  cov_write: cover property (wr_fire);
  cov_buzzer: cover property (alt_en[P14][BUZ_BIT] && P14_OE[1]);
  cov_key: cover property (KEY_IRQ_INPUTS != 8'h00);

endmodule

// file: pkg/mgp_pkg.sv
// Constants for the multiplexed GPIO port block
package mgp_pkg;

  localparam int NPORT = 8;
  localparam int PW    = 8;

  // Port slots, one byte lane of state each
  localparam int P3  = 0;
  localparam int P4  = 1;
  localparam int P5  = 2;
  localparam int P6  = 3;
  localparam int P7  = 4;
  localparam int P12 = 5;
  localparam int P13 = 6;
  localparam int P14 = 7;

  // Register map: port slot in addr[6:4], field in addr[3:2]
  localparam logic [7:0] OFS_EDGE  = 8'h80;
  localparam logic [1:0] FLD_DATA  = 2'h0;
  localparam logic [1:0] FLD_DIR   = 2'h1;
  localparam logic [1:0] FLD_PULL  = 2'h2;
  localparam logic [1:0] FLD_MODE  = 2'h3;

  // Reset values; direction 1 means input
  localparam logic [7:0]  RST_LATCH = 8'h00;
  localparam logic [7:0]  RST_DIR   = 8'hFF;
  localparam logic [7:0]  RST_PULL  = 8'h00;
  localparam logic [7:0]  RST_MODE  = 8'h00;
  localparam logic [15:0] RST_EDGE  = 16'h0000;

  // Edge select per interrupt, two bits each
  localparam int EDGE_RISE = 0;
  localparam int EDGE_FALL = 1;

  localparam logic [1:0] RESP_OK     = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;

  // Implemented bits of each port
  localparam logic [7:0] BIT_MASK [NPORT] =
    '{8'h0F, 8'h0F, 8'h0F, 8'h0F, 8'hFF, 8'h01, 8'h01, 8'h03};
  localparam logic [7:0] DIR_MASK [NPORT] =
    '{8'h0F, 8'h0F, 8'h0F, 8'h0F, 8'hFF, 8'h01, 8'h00, 8'h03};
  localparam logic [7:0] PULL_MASK [NPORT] =
    '{8'h0F, 8'h0F, 8'h0F, 8'h00, 8'hFF, 8'h01, 8'h00, 8'h03};
  localparam logic [7:0] MODE_MASK [NPORT] =
    '{8'h0F, 8'h00, 8'h00, 8'h00, 8'hFF, 8'h01, 8'h00, 8'h03};
  // Bits whose alternate function can drive the pin
  localparam logic [7:0] ALT_OUT_MASK [NPORT] =
    '{8'h08, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h03};

  // External interrupt sources; entry 5 lives elsewhere
  localparam logic [7:0] IRQ_USED = 8'hDF;
  localparam int IRQ_PORT [8] = '{P12, P3, P3, P3, P3, P3, P14, P14};
  localparam int IRQ_BIT  [8] = '{0, 0, 1, 2, 3, 3, 0, 1};

  localparam int TMR_BIT = 3;
  localparam int CLK_BIT = 0;
  localparam int BUZ_BIT = 1;

endpackage

// file: tb/mgp_pin_board.sv
// Board model of one port: pin level seen back by the block
`timescale 1ns/1ps
module mgp_pin_board
#(
  parameter int W = 4
)
(
  input  wire logic [W-1:0] out,
  input  wire logic [W-1:0] oe,
  input  wire logic [W-1:0] ext,
  output logic      [W-1:0] lvl
);
  // Board always drives released pins, so a pull-up never shows on the level
  assign lvl = (oe & out) | (~oe & ext);
endmodule

// file: tb/test_multiplexed_gpio_ports.sv
// Self-checking bench for the multiplexed GPIO port block
`timescale 1ns/1ps
module test_multiplexed_gpio_ports;
  import mgp_pkg::*;
  logic        clk = 1'b0;
  logic        rst_b = 1'b0;
  logic [7:0]  adr = 8'h00;
  logic        rd = 1'b0;
  logic        wr = 1'b0;
  logic [31:0] wd = 32'h0000_0000;
  logic [3:0]  be = 4'hF;
  logic [31:0] rdata;
  logic        wait_req;
  logic [1:0]  resp;
  logic [3:0]  o3, e3, u3, o4, e4, u4, o5, e5, u5, o6, e6;
  logic [3:0]  l3, l4, l5, l6;
  logic [7:0]  o7, e7, u7, l7, key, irq;
  logic        o12, e12, u12, l12, only, tcin;
  logic [1:0]  o14, e14, u14, l14;
  logic        tbo = 1'b0;
  logic        cks = 1'b0;
  logic        bzs = 1'b0;
  logic [7:0]  ext [8];
  logic [7:0]  oev [8];
  logic [7:0]  outv [8];
  logic [7:0]  puv [8];
  logic [33:0] expq [$];
  int          n_fail = 0;
  int          comparisons = 0;
  int          seed = 41293;
  int          npulse = 0;
  int          cur = 0;

  // 20 MHz system clock; only the true phase reaches this block
  always #25 clk = ~clk;

  mgp_top dut (.CLK_SYS(clk), .RST_B(rst_b), .AVS_ADDRESS(adr),
    .AVS_READ(rd), .AVS_WRITE(wr), .AVS_WRITEDATA(wd),
    .AVS_BYTEENABLE(be), .AVS_READDATA(rdata),
    .AVS_WAITREQUEST(wait_req), .AVS_RESPONSE(resp),
    .P3_IN(l3), .P3_OUT(o3), .P3_OE(e3), .P3_PULLUP(u3),
    .P4_IN(l4), .P4_OUT(o4), .P4_OE(e4), .P4_PULLUP(u4),
    .P5_IN(l5), .P5_OUT(o5), .P5_OE(e5), .P5_PULLUP(u5),
    .P6_IN(l6), .P6_OUT(o6), .P6_OE(e6),
    .P7_IN(l7), .P7_OUT(o7), .P7_OE(e7), .P7_PULLUP(u7),
    .P12_IN(l12), .P12_OUT(o12), .P12_OE(e12), .P12_PULLUP(u12),
    .OUTPUT_ONLY_PIN(only),
    .P14_IN(l14), .P14_OUT(o14), .P14_OE(e14), .P14_PULLUP(u14),
    .TIMER_B_OUT(tbo), .CLOCK_OUT_SRC(cks), .BUZZER_SRC(bzs),
    .TIMER_B_COUNT_IN(tcin), .KEY_IRQ_INPUTS(key), .EXT_IRQ(irq));

  // One board model per port with input pins; the output-only pin has none
  // Four-bit ports use the model's default width
  mgp_pin_board b3 (.out(o3), .oe(e3), .ext(ext[P3][3:0]), .lvl(l3));
  mgp_pin_board b4 (.out(o4), .oe(e4), .ext(ext[P4][3:0]), .lvl(l4));
  mgp_pin_board b5 (.out(o5), .oe(e5), .ext(ext[P5][3:0]), .lvl(l5));
  mgp_pin_board b6 (.out(o6), .oe(e6), .ext(ext[P6][3:0]), .lvl(l6));
  mgp_pin_board #(.W(8)) b7 (.out(o7), .oe(e7), .ext(ext[P7]), .lvl(l7));
  mgp_pin_board #(.W(1)) b12 (.out(o12), .oe(e12), .ext(ext[P12][0]),
    .lvl(l12));
  mgp_pin_board #(.W(2)) b14 (.out(o14), .oe(e14), .ext(ext[P14][1:0]),
    .lvl(l14));

  // Pin outputs gathered by port slot for loop-driven checks
  always_comb
  begin
    oev = '{8'(e3), 8'(e4), 8'(e5), 8'(e6), e7, 8'(e12), 8'h00, 8'(e14)};
    outv = '{8'(o3), 8'(o4), 8'(o5), 8'(o6), o7, 8'(o12), 8'(only), 8'(o14)};
    puv = '{8'(u3), 8'(u4), 8'(u5), 8'h00, u7, 8'(u12), 8'h00, 8'(u14)};
  end

  task automatic chk(input string nm, input logic [31:0] e,
                     input logic [31:0] s);
    comparisons++;
    if (s !== e)
    begin
      n_fail++;
      $display("unexpected %s: expected %h seen %h", nm, e, s);
    end
  endtask

  task give_verdict;
    if (n_fail == 0 && comparisons > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  function automatic logic [7:0] ad(input int s, input logic [1:0] f);
    return 8'(s * 16) | {4'h0, f, 2'b00};
  endfunction

  // Bus master: holds the request until waitrequest is sampled low
  task automatic bus(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    @(posedge clk);
    adr <= a;
    rd <= ~w;
    wr <= w;
    wd <= d;
    @(posedge clk);
    while (wait_req !== 1'b0)
      @(posedge clk);
    rd <= 1'b0;
    wr <= 1'b0;
  endtask

  task automatic wrr(input logic [7:0] a, input logic [31:0] d);
    bus(1'b1, a, d);
  endtask

  task automatic rdx(input logic [7:0] a, input logic [31:0] e,
                     input logic [1:0] r);
    expq.push_back({r, e});
    bus(1'b0, a, 32'h0000_0000);
  endtask

  // Drive, sync plus filter latency on pin inputs (five edges), then three spare edges
  task automatic settle();
    repeat (8) @(posedge clk);
  endtask

  // Read answers matched against the oldest noted expectation
  always @(posedge clk)
    if (rd && wait_req === 1'b0)
    begin
      chk("readdata", expq[0][31:0], rdata);
      chk("response", 32'(expq[0][33:32]), 32'(resp));
      void'(expq.pop_front());
    end

  // Pulse counter on the interrupt line under test
  always @(posedge clk)
    if (irq[cur] === 1'b1)
      npulse++;

  // Watchdog well past the expected run length
  initial
  begin
    #(20000 * 50);
    n_fail++;
    give_verdict();
  end

  // Main sequence
  initial
  begin
    int s;
    logic [7:0] d, l, p, m, b;
    logic [1:0] cfg;
    logic [2:0] alt;
    int sl [7] = '{P3, P4, P5, P6, P7, P12, P14};
    for (int k = 0; k < 8; k++)
      ext[k] = 8'($random(seed));
    repeat (3) @(posedge clk);
    rst_b <= 1'b1;
    chk("oe_reset", 0, {e3, e4, e5, e6, e7, e12, e14});
    for (int k = 0; k < NPORT; k++)
      rdx(ad(k, FLD_DIR), RST_DIR & DIR_MASK[k], RESP_OK);
    wrr(8'hC4, 32'hFFFF_FFFF);
    rdx(8'hC4, 0, RESP_SLVERR);
    // Write with byte lane 0 disabled must leave the register alone
    be <= 4'h0;
    wrr(ad(P4, FLD_DIR), 32'h0000_0000);
    be <= 4'hF;
    rdx(ad(P4, FLD_DIR), RST_DIR & DIR_MASK[P4], RESP_OK);
    for (int r = 0; r < 2; r++)
      foreach (sl[i])
      begin
        s = sl[i];
        d = 8'($random(seed));
        l = 8'($random(seed));
        p = 8'($random(seed));
        ext[s] <= 8'($random(seed));
        wrr(ad(s, FLD_DATA), l);
        wrr(ad(s, FLD_DIR), d);
        wrr(ad(s, FLD_PULL), p);
        settle();
        m = DIR_MASK[s] & ~d;
        if (s == P6)
          m = m & ~l;
        chk("oe", m, oev[s]);
        chk("out", l & m, outv[s] & oev[s]);
        chk("pullup", p & d & PULL_MASK[s], puv[s]);
        rdx(ad(s, FLD_DATA), ((l & ~d) | (ext[s] & d)) & BIT_MASK[s],
            RESP_OK);
      end
    wrr(ad(P6, FLD_DATA), 0);
    wrr(ad(P13, FLD_DATA), 1);
    wrr(ad(P7, FLD_MODE), 8'hFF);
    for (int n = 0; n < 8; n++)
      if (IRQ_USED[n])
      begin
        s = IRQ_PORT[n];
        b = 8'h01 << IRQ_BIT[n];
        cfg = 2'(n % 3 + 1);
        ext[s] <= ext[s] & ~b;
        wrr(ad(s, FLD_DIR), 8'hFF);
        wrr(ad(s, FLD_MODE), b);
        wrr(OFS_EDGE, 32'(cfg) << (2 * n));
        settle();
        cur = n;
        npulse = 0;
        ext[s] <= ext[s] | b;
        settle();
        if (n == 4)
          chk("timer_in", 1, tcin);
        ext[s] <= ext[s] & ~b;
        settle();
        chk("pulses", (cfg == 2'h3) ? 2 : 1, npulse);
      end
    // Last edge write left only entry 7 on falling edges
    rdx(OFS_EDGE, 32'h0000_8000, RESP_OK);
    chk("output_only", 1, only);
    chk("key_oe", 0, e7);
    chk("key_in", ext[P7], key);
    // Latches hold the opposite of each source, so a missed route shows
    alt = 3'($random(seed));
    cks <= alt[2];
    bzs <= alt[1];
    tbo <= alt[0];
    wrr(ad(P14, FLD_DATA), 32'({~alt[1], ~alt[2]}));
    wrr(ad(P3, FLD_DATA), 32'({~alt[0], 3'b000}));
    wrr(ad(P14, FLD_DIR), 0);
    wrr(ad(P14, FLD_MODE), 3);
    wrr(ad(P3, FLD_DIR), 8'h07);
    wrr(ad(P3, FLD_MODE), 8'h08);
    settle();
    chk("alt_out", {alt[1], alt[2], alt[0]}, {o14, o3[3]});
    chk("alt_oe", 3'b111, {e14, e3[3]});
    rst_b <= 1'b0;
    repeat (3) @(posedge clk);
    rst_b <= 1'b1;
    chk("oe_midreset", 0, {e3, e14, e6});
    rdx(ad(P14, FLD_MODE), 0, RESP_OK);
    settle();
    give_verdict();
  end
endmodule
